// ==== core/aeif_pkg.sv ====
// Overview of operation
// R1: Enable bit 7 gates illegal access interrupt
// R2: Enable bit 6 gates command value interrupt
// R3: Enable bit 5 gates missing list-end interrupt
// R4: Enable bit 3 gates trigger error interrupt
// R5: Enable bit 2 gates restart request interrupt
// R6: Enable bit 1 gates load-ready error interrupt
// R7: Event enable bit 7 gates abort-done interrupt
// R8: Event enable bit 6 gates flag overrun interrupt
// R9: Severe flags halt converter; read-only
// R10: Soft reset clears severe flags
// R11: Restart and load-ready errors do not halt
// R12: Writing one clears recoverable flags anytime
// R13: Soft reset clears recoverable flags too
// R14: Converter disabled holds all flags cleared
// R15: Writing zero keeps; writing one never sets
// R16: Illegal access event sets flag bit 7
// R17: Bad command or format sets bit 6
// R18: Missing list end sets bit 5
// R19: Restart mode trigger after abort sets bit 3; code sets it on any restart-mode trigger
// R20: Restart before list end sets bit 2
// R21: Restart without load-ready sets bit 1
// R22: Interrupt asserted while flag and enable set
package aeif_pkg;

  // ****************************************
  // Register map (printed offsets are indices)
  // ****************************************
  localparam logic [3:0] AEIF_IDX_ERR_EN = 4'h6;
  localparam logic [3:0] AEIF_IDX_EVT_EN = 4'h7;
  localparam logic [3:0] AEIF_IDX_FLAGS = 4'h8;
  localparam logic [3:0] AEIF_IDX_CTRL = 4'h9;
  localparam logic [3:0] AEIF_IDX_EVT_STAT = 4'hA;

  localparam int AEIF_BIT_IA = 7;
  localparam int AEIF_BIT_CMD = 6;
  localparam int AEIF_BIT_EOL = 5;
  localparam int AEIF_BIT_TRIG = 3;
  localparam int AEIF_BIT_RSTAR = 2;
  localparam int AEIF_BIT_LOAD_READY_BIT = 1;
  localparam int AEIF_BIT_SEQAD = 7;
  localparam int AEIF_BIT_OVR = 6;
  localparam int AEIF_BIT_CONV_EN = 0;

  localparam logic [7:0] AEIF_ERR_MASK = 8'hEE;
  localparam logic [7:0] AEIF_SEVERE_MASK = 8'hE8;
  localparam logic [7:0] AEIF_W1C_MASK = 8'h06;
  localparam logic [7:0] AEIF_EVT_MASK = 8'hC0;
  localparam logic [7:0] AEIF_RESET_BYTE = 8'h00;

  localparam logic [1:0] AEIF_RESP_OKAY = 2'h0;
  localparam logic [1:0] AEIF_RESP_SLVERR = 2'h2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic illegal_access;
    logic bad_command;
    logic bad_format;
    logic missing_list_end;
    logic trigger;
    logic restart_request;
    logic sequence_abort;
    logic abort_active;
    logic restart_mode;
    logic load_ready_bit;
    logic list_end_done;
    logic lde_exempt;
    logic abort_done;
    logic conv_overrun;
  } aeif_events_type;

  typedef struct packed {
    logic illegal_access_err_irq;
    logic bad_command_err_irq;
    logic missing_list_end_err_irq;
    logic trigger_err_irq;
    logic restart_request_err_irq;
    logic load_ready_err_irq;
    logic abort_done_irq;
    logic conv_flag_overrun_irq;
  } aeif_irqs_type;

endpackage

// ==== core/aeif_top.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module aeif_top (
  input wire logic aclk, // 125 MHz clock
  input wire logic aresetn, // Sync reset, low active
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic soft_reset, // Converter soft reset pulse
  input wire aeif_pkg::aeif_events_type events, // Error/event sources
  output aeif_pkg::aeif_irqs_type irqs, // Interrupt requests
  output logic conv_halt, // Severe error stops conversion
  output logic conv_enable // Converter enable bit
);
  import aeif_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] err_en_q;
  logic [7:0] evt_en_q;
  logic [7:0] flags_q, flags_d;
  logic [7:0] evt_stat_q, evt_stat_d;
  logic conv_en_q;
  logic [3:0] aw_idx_q, ar_idx_q;
  logic aw_ok_q, ar_ok_q;
  logic aw_have_q, w_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  function automatic logic idx_ok(input logic [31:0] a);
    idx_ok = (a[1:0] == 2'h0) && (a[31:6] == 26'h0) &&
      ((a[5:2] == AEIF_IDX_ERR_EN) || (a[5:2] == AEIF_IDX_EVT_EN) ||
      (a[5:2] == AEIF_IDX_FLAGS) || (a[5:2] == AEIF_IDX_CTRL) ||
      (a[5:2] == AEIF_IDX_EVT_STAT));
  endfunction

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic wr_fire;
  logic [7:0] wbyte;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wbyte = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AEIF_RESP_OKAY;
      aw_idx_q <= 4'h0;
      aw_ok_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[5:2];
        aw_ok_q <= idx_ok(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= aw_ok_q ? AEIF_RESP_OKAY : AEIF_RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_err_en, wr_evt_en, wr_flags, wr_ctrl;
  assign wr_err_en = wr_fire && aw_ok_q && wstrb_q[0] && (aw_idx_q == AEIF_IDX_ERR_EN);
  assign wr_evt_en = wr_fire && aw_ok_q && wstrb_q[0] && (aw_idx_q == AEIF_IDX_EVT_EN);
  assign wr_flags = wr_fire && aw_ok_q && wstrb_q[0] && (aw_idx_q == AEIF_IDX_FLAGS);
  assign wr_ctrl = wr_fire && aw_ok_q && wstrb_q[0] && (aw_idx_q == AEIF_IDX_CTRL);

  // ****************************************
  // Enables and control
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_en_q <= AEIF_RESET_BYTE;
      evt_en_q <= AEIF_RESET_BYTE;
      conv_en_q <= 1'b0;
    end else begin
      if (wr_err_en) begin
        err_en_q <= wbyte & AEIF_ERR_MASK; // R1 R2 R3 R4 R5 R6
      end
      if (wr_evt_en) begin
        evt_en_q <= wbyte & AEIF_EVT_MASK; // R7 R8
      end
      if (wr_ctrl) begin
        conv_en_q <= wbyte[AEIF_BIT_CONV_EN];
      end
    end
  end

  // ****************************************
  // Error flags
  // ****************************************
  // Set wins over a same-cycle write-one clear; soft reset and disable win over all.
  logic [7:0] set_v;
  always_comb begin
    set_v = 8'h00;
    set_v[AEIF_BIT_IA] = events.illegal_access; // R16
    set_v[AEIF_BIT_CMD] = events.bad_command || events.bad_format; // R17
    set_v[AEIF_BIT_EOL] = events.missing_list_end; // R18
    set_v[AEIF_BIT_TRIG] = events.restart_mode && events.trigger; // R19
    set_v[AEIF_BIT_RSTAR] = events.restart_request && !events.list_end_done
      && !events.abort_active && !events.sequence_abort; // R20
    set_v[AEIF_BIT_LOAD_READY_BIT] = events.restart_mode && events.restart_request
      && !events.load_ready_bit && !events.abort_active
      && !events.sequence_abort && !events.lde_exempt; // R21
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_q & ~(wbyte & AEIF_W1C_MASK); // R12 R15
    end
    flags_d = flags_d | set_v; // R15
    if (soft_reset) begin
      flags_d = AEIF_RESET_BYTE; // R10 R13
    end
    if (!conv_en_q) begin
      flags_d = AEIF_RESET_BYTE; // R14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= AEIF_RESET_BYTE;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ****************************************
  // Event status (abort done, overrun)
  // ****************************************
  always_comb begin
    evt_stat_d = evt_stat_q;
    if (wr_fire && aw_ok_q && wstrb_q[0] && (aw_idx_q == AEIF_IDX_EVT_STAT)) begin
      evt_stat_d = evt_stat_q & ~(wbyte & AEIF_EVT_MASK);
    end
    evt_stat_d[AEIF_BIT_SEQAD] = evt_stat_d[AEIF_BIT_SEQAD] | events.abort_done;
    evt_stat_d[AEIF_BIT_OVR] = evt_stat_d[AEIF_BIT_OVR] | events.conv_overrun;
    if (soft_reset || !conv_en_q) begin
      evt_stat_d = AEIF_RESET_BYTE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_q <= AEIF_RESET_BYTE;
    end else begin
      evt_stat_q <= evt_stat_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Registered from next-state so requests track the flags in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irqs <= '0;
      conv_halt <= 1'b0;
      conv_enable <= 1'b0;
    end else begin
      irqs.illegal_access_err_irq <= flags_d[AEIF_BIT_IA] && err_en_q[AEIF_BIT_IA]; // R1 R22
      irqs.bad_command_err_irq <= flags_d[AEIF_BIT_CMD] && err_en_q[AEIF_BIT_CMD]; // R2 R22
      irqs.missing_list_end_err_irq <= flags_d[AEIF_BIT_EOL]
        && err_en_q[AEIF_BIT_EOL]; // R3
      irqs.trigger_err_irq <= flags_d[AEIF_BIT_TRIG] && err_en_q[AEIF_BIT_TRIG]; // R4
      irqs.restart_request_err_irq <= flags_d[AEIF_BIT_RSTAR]
        && err_en_q[AEIF_BIT_RSTAR]; // R5
      irqs.load_ready_err_irq <= flags_d[AEIF_BIT_LOAD_READY_BIT] && err_en_q[AEIF_BIT_LOAD_READY_BIT]; // R6
      irqs.abort_done_irq <= evt_stat_d[AEIF_BIT_SEQAD] && evt_en_q[AEIF_BIT_SEQAD]; // R7
      irqs.conv_flag_overrun_irq <= evt_stat_d[AEIF_BIT_OVR] && evt_en_q[AEIF_BIT_OVR]; // R8
      conv_halt <= |(flags_d & AEIF_SEVERE_MASK); // R9 R11
      conv_enable <= conv_en_q;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AEIF_RESP_OKAY;
      ar_idx_q <= 4'h0;
      ar_ok_q <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= idx_ok(s_axi_araddr) ? AEIF_RESP_OKAY : AEIF_RESP_SLVERR;
        if (s_axi_araddr[5:2] == AEIF_IDX_ERR_EN) begin
          s_axi_rdata <= {24'h0, err_en_q};
        end else if (s_axi_araddr[5:2] == AEIF_IDX_EVT_EN) begin
          s_axi_rdata <= {24'h0, evt_en_q};
        end else if (s_axi_araddr[5:2] == AEIF_IDX_FLAGS) begin
          s_axi_rdata <= {24'h0, flags_q};
        end else if (s_axi_araddr[5:2] == AEIF_IDX_CTRL) begin
          s_axi_rdata <= {31'h0, conv_en_q};
        end else if (s_axi_araddr[5:2] == AEIF_IDX_EVT_STAT) begin
          s_axi_rdata <= {24'h0, evt_stat_q};
        end else begin
          s_axi_rdata <= 32'h0;
        end
        if (!idx_ok(s_axi_araddr)) begin
          s_axi_rdata <= 32'h0;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  logic unused_ok;
  assign unused_ok = ar_ok_q | (|ar_idx_q) | (|wdata_q[31:8]) | (|wstrb_q[3:1]);

endmodule

// ==== test/aeif_top_sva.sv ====
`timescale 1ns/10ps
module aeif_top_sva (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low active
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_rvalid, // Read valid
  input wire logic s_axi_rready, // Read ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic soft_reset, // Soft reset
  input wire aeif_pkg::aeif_events_type events, // Event sources
  input wire aeif_pkg::aeif_irqs_type irqs, // Interrupt requests
  input wire logic conv_halt, // Halt
  input wire logic conv_enable // Converter enable
);
  import aeif_pkg::*;
  logic sev_ev;
  assign sev_ev = |events[13:9];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  soft_severe_a: assert property (soft_reset |=> !conv_halt)
    else $error("halt survived soft reset");
  soft_recov_a: assert property (soft_reset |=> !irqs.restart_request_err_irq &&
    !irqs.load_ready_err_irq) else $error("recoverable irq survived soft reset");
  disabled_clear_a: assert property (!conv_enable [*2] |-> !conv_halt &&
    !irqs.load_ready_err_irq) else $error("flags set while disabled");
  ia_halts_a: assert property (events.illegal_access && conv_enable && !soft_reset
    |=> conv_halt || !conv_enable) else $error("illegal access did not halt");
  irq_needs_flag_a: assert property (irqs.illegal_access_err_irq |-> conv_halt)
    else $error("irq without severe flag");
  halt_cause_a: assert property ($rose(conv_halt) |-> $past(sev_ev))
    else $error("halt rose without error event");
  load_ready_bit_fall_a: assert property ($fell(irqs.load_ready_err_irq) |-> $past(soft_reset) ||
    $rose(s_axi_bvalid) || !conv_enable) else $error("irq fell without cause");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind aeif_top aeif_top_sva i_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .soft_reset(soft_reset), .events(events), .irqs(irqs), .conv_halt(conv_halt),
  .conv_enable(conv_enable));

// ==== test/aeif_top_tb.sv ====
`timescale 1ns/10ps
module aeif_top_tb;
  import aeif_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, conv_halt, conv_enable, soft_reset = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d;
  logic [1:0] bresp, rresp;
  aeif_events_type events = '0;
  aeif_irqs_type irqs;
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #4 aclk = ~aclk;
  aeif_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .soft_reset(soft_reset), .events(events), .irqs(irqs), .conv_halt(conv_halt),
    .conv_enable(conv_enable));
  task automatic test_done;
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk(bresp, r);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    v = rdata;
    chk(rresp, r);
  endtask
  task automatic ev(input logic [13:0] e);
    @(posedge aclk) events <= e;
    @(posedge aclk) events <= '0;
    @(posedge aclk);
  endtask
  task automatic sr;
    @(posedge aclk) soft_reset <= 1;
    @(posedge aclk) soft_reset <= 0;
    @(posedge aclk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_severe;
    // Trigger error only counts in restart mode, so that event rides along
    logic [13:0] se [5] = '{14'h2000, 14'h1000, 14'h0800, 14'h0400, 14'h0220};
    logic [7:0] fl [5] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h08};
    logic [7:0] iq [5] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h10};
    for (int i = 0; i < 5; i++) begin
      ev(se[i]);
      rd(32'h20, d, AEIF_RESP_OKAY);
      chk(d, fl[i]);
      chk(conv_halt, 1);
      chk(irqs, iq[i]);
      wr(32'h18, 32'h00, AEIF_RESP_OKAY);
      // Requests follow the enable register one edge after the write lands
      @(posedge aclk);
      chk(irqs, 0);
      wr(32'h18, 32'hFF, AEIF_RESP_OKAY);
      wr(32'h20, 32'hFF, AEIF_RESP_OKAY);
      rd(32'h20, d, AEIF_RESP_OKAY);
      chk(d, fl[i]);
      sr;
      rd(32'h20, d, AEIF_RESP_OKAY);
      chk(d, 0);
      chk(conv_halt, 0);
    end
  endtask
  task automatic t_recov;
    ev(14'h0120);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d & 32'h2, 32'h2);
    chk(conv_halt, 0);
    chk(irqs.load_ready_err_irq, 1);
    wr(32'h20, 32'h00, AEIF_RESP_OKAY);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d & 32'h2, 32'h2);
    wr(32'h20, 32'h06, AEIF_RESP_OKAY);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d, 0);
    ev(14'h0100);
    ev(14'h01A0);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d & 32'h2, 0);
    ev(14'h0120);
    sr;
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d, 0);
  endtask
  task automatic t_event;
    ev(14'h0002);
    chk(irqs.abort_done_irq, 1);
    ev(14'h0001);
    chk(irqs.conv_flag_overrun_irq, 1);
    wr(32'h1C, 32'h00, AEIF_RESP_OKAY);
    @(posedge aclk);
    chk(irqs[1:0], 0);
    wr(32'h28, 32'hFF, AEIF_RESP_OKAY);
  endtask
  task automatic t_disable;
    ev(14'h2120);
    wr(32'h24, 32'h00, AEIF_RESP_OKAY);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d, 0);
    ev(14'h2000);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d, 0);
    chk(conv_halt, 0);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    foreach (d[i]) begin end
    rd(32'h18, d, AEIF_RESP_OKAY);
    chk(d, 0);
    rd(32'h20, d, AEIF_RESP_OKAY);
    chk(d, 0);
    wr(32'h18, 32'hFF, AEIF_RESP_OKAY);
    rd(32'h18, d, AEIF_RESP_OKAY);
    chk(d, 32'hEE);
    wr(32'h1C, 32'hFF, AEIF_RESP_OKAY);
    rd(32'h1C, d, AEIF_RESP_OKAY);
    chk(d, 32'hC0);
    rd(32'h3C, d, AEIF_RESP_SLVERR);
    chk(d, 0);
    wr(32'h24, 32'h01, AEIF_RESP_OKAY);
    t_severe;
    t_recov;
    t_event;
    t_disable;
    test_done;
  end
endmodule
